/* hdl/brtc_defines.vh */
`ifndef BRTC_DEFINES_VH
`define BRTC_DEFINES_VH

// Register indices; the byte address is four times the index.
// The timeout byte is lane 1 of the word at index 11h, byte address 45h.
`define BRTC_IDX_TOCTL 12'h011
`define BRTC_TOCTL_LANE 8
`define BRTC_IDX_STATUS 12'h050
`define BRTC_IDX_MASK 12'h051
`define BRTC_IDX_CTRL 12'h052

// Timeout control fields.
`define BRTC_RETRY_LSB 0
`define BRTC_RETRY_MSB 2
`define BRTC_RSVD_BIT 3
`define BRTC_PDIV_LSB 4
`define BRTC_PDIV_MSB 5
`define BRTC_SDIV_LSB 6
`define BRTC_SDIV_MSB 7

// Control fields.
`define BRTC_CTRL_PSERR_EN 0
`define BRTC_CTRL_SSERR_EN 1
`define BRTC_CTRL_PBASE_1K 2
`define BRTC_CTRL_SBASE_1K 3

// Status and mask bits.
`define BRTC_EV_PRETRY 0
`define BRTC_EV_SRETRY 1
`define BRTC_EV_PMTO 2
`define BRTC_EV_SMTO 3

// Reset values.
`define BRTC_TOCTL_RST 8'h00
`define BRTC_CTRL_RST 8'h00
`define BRTC_MASK_RST 4'h0
`define BRTC_STATUS_RST 4'h0

// Retry limit encodings and their exponents.
`define BRTC_RL_E24 3'h0
`define BRTC_RL_E18 3'h1
`define BRTC_RL_E12 3'h2
`define BRTC_RL_E6 3'h3
`define BRTC_RL_E0 3'h7
`define BRTC_RCNT_W 25

// Master timeout base values in clocks.
`define BRTC_MTO_BASE_32K 17'h08000
`define BRTC_MTO_BASE_1K 17'h00400

// Divider encodings and their divisors.
`define BRTC_DIV_1 2'h0
`define BRTC_DIV_8 2'h1
`define BRTC_DIV_16 2'h2
`define BRTC_DIV_256 2'h3

`endif

/* hdl/brtc_port.v */
`timescale 1ns/1ps
`include "brtc_defines.vh"

module brtc_port (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Settings
    input wire [2:0] retry_limit,
    input wire [1:0] div_sel,
    input wire base_1k,
    // Transaction events
    input wire retry,
    input wire xact_done,
    input wire mto_start,
    input wire mto_stop,
    // Timeout pulses
    output reg retry_timeout,
    output reg master_timeout
);

reg [`BRTC_RCNT_W-1:0] retry_cnt;
reg [`BRTC_RCNT_W-1:0] limit;
reg [16:0] mto_cnt;
reg [16:0] mto_load;
reg [16:0] base;
reg mto_run;

////////////////////////////////////////////////////////////////////////////////

always @* begin
    case (retry_limit)
        `BRTC_RL_E24: limit = 25'h1000000;
        `BRTC_RL_E18: limit = 25'h0040000;
        `BRTC_RL_E12: limit = 25'h0001000;
        `BRTC_RL_E6: limit = 25'h0000040;
        // Undefined codes fall back to the shortest limit.
        default: limit = 25'h0000001;
    endcase
end

always @* begin
    base = base_1k ? `BRTC_MTO_BASE_1K : `BRTC_MTO_BASE_32K;
    case (div_sel)
        `BRTC_DIV_8: mto_load = base >> 3;
        `BRTC_DIV_16: mto_load = base >> 4;
        `BRTC_DIV_256: mto_load = base >> 8;
        default: mto_load = base;
    endcase
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        retry_cnt <= 25'h0000000;
        retry_timeout <= 1'b0;
        mto_cnt <= 17'h00000;
        mto_run <= 1'b0;
        master_timeout <= 1'b0;
    end else begin
        retry_timeout <= 1'b0;
        master_timeout <= 1'b0;
        if (xact_done) begin
            retry_cnt <= 25'h0000000;
        end else if (retry) begin
            if (retry_cnt + 25'h0000001 >= limit) begin
                retry_cnt <= 25'h0000000;
                retry_timeout <= 1'b1;
            end else begin
                retry_cnt <= retry_cnt + 25'h0000001;
            end
        end
        if (mto_stop) begin
            mto_run <= 1'b0;
        end else if (mto_start) begin
            mto_run <= 1'b1;
            mto_cnt <= mto_load - 17'h00001;
        end else if (mto_run) begin
            if (mto_cnt == 17'h00000) begin
                mto_run <= 1'b0;
                master_timeout <= 1'b1;
            end else begin
                mto_cnt <= mto_cnt - 17'h00001;
            end
        end
    end
end

endmodule // brtc_port

/* hdl/brtc_top.v */
// Behaviour
// - A three-bit retry-limit field bounds how often a target-retried transaction is repeated.
// - Codes 000, 001, 010, 011 and 111 give 2^24, 2^18, 2^12, 2^6 and 2^0 retries; reset zero.
// - Retry timeouts cover reads and writes and raise the system error on an enabled port.
// - The primary divider in bits 5:4 divides the primary master timeout by 1, 8, 16 or 256.
// - The secondary divider in bits 7:6 scales the secondary timeout the same way.
// - Each master timeout base is 32K clocks or 1K when selected, divided afterwards.
// - The timeout control register sits at byte offset 45h, lane 1 of the word at 44h.
`timescale 1ns/1ps
`include "brtc_defines.vh"

module brtc_top (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [13:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Primary side transaction events
    input wire pri_retry,
    input wire pri_xact_done,
    input wire pri_mto_start,
    input wire pri_mto_stop,
    // Secondary side transaction events
    input wire sec_retry,
    input wire sec_xact_done,
    input wire sec_mto_start,
    input wire sec_mto_stop,
    // Timeout pulses to the bridge core
    output wire pri_retry_timeout,
    output wire sec_retry_timeout,
    output wire pri_master_timeout,
    output wire sec_master_timeout,
    // Open-drain system error pins
    output reg pri_serr_out,
    output reg pri_serr_oe_n,
    output reg sec_serr_out,
    output reg sec_serr_oe_n,
    // Interrupt
    output reg irq
);

reg [7:0] toctl;
reg [7:0] ctrl;
reg [3:0] status;
reg [3:0] mask;
reg [31:0] rd_word;
reg [3:0] next_status;
wire [11:0] reg_idx;
wire wr_go;
wire rd_done;
wire wr_toctl;
wire wr_mask;
wire wr_ctrl;
wire rd_clear;
wire any_rto;
wire [3:0] events;

////////////////////////////////////////////////////////////////////////////////

assign reg_idx = wb_adr_i[13:2];
// The access completes on the edge where the master sees ack.
assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
assign rd_done = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o;

// byte lane of offset 45h
// Each register listens only to the byte lane it lives in.
assign wr_toctl = wr_go & wb_sel_i[1] & (reg_idx == `BRTC_IDX_TOCTL);
assign wr_mask = wr_go & wb_sel_i[0] & (reg_idx == `BRTC_IDX_MASK);
assign wr_ctrl = wr_go & wb_sel_i[0] & (reg_idx == `BRTC_IDX_CTRL);
// Status clears at the acknowledged edge only, so one read clears once.
assign rd_clear = rd_done & (reg_idx == `BRTC_IDX_STATUS);

////////////////////////////////////////////////////////////////////////////////

// Unmapped words and unused lanes read as zero.
always @* begin
    rd_word = 32'h00000000;
    if (reg_idx == `BRTC_IDX_TOCTL) begin
        rd_word[`BRTC_TOCTL_LANE+7:`BRTC_TOCTL_LANE] = toctl & 8'hf7;
    end else if (reg_idx == `BRTC_IDX_STATUS) begin
        rd_word[7:0] = {4'h0, status};
    end else if (reg_idx == `BRTC_IDX_MASK) begin
        rd_word[7:0] = {4'h0, mask};
    end else if (reg_idx == `BRTC_IDX_CTRL) begin
        rd_word[7:0] = {4'h0, ctrl[3:0]};
    end
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        // Read data is captured with the ack and held until the next request.
        if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
            wb_dat_o <= rd_word;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        toctl <= `BRTC_TOCTL_RST;
        ctrl <= `BRTC_CTRL_RST;
        // Mask defaults to all events blocked.
        mask <= `BRTC_MASK_RST;
    end else begin
        if (wr_toctl) begin
            toctl <= wb_dat_i[`BRTC_TOCTL_LANE+7:`BRTC_TOCTL_LANE] & 8'hf7;
        end
        if (wr_mask) begin
            mask <= wb_dat_i[3:0];
        end
        // Only the four defined control bits are stored.
        if (wr_ctrl) begin
            ctrl <= {4'h0, wb_dat_i[3:0]};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// Both ports share the retry limit field; each has its own divider and base.
// primary retry limiter
brtc_port u_pri (
    .core_clk(core_clk),
    .rst(rst),
    .retry_limit(toctl[`BRTC_RETRY_MSB:`BRTC_RETRY_LSB]),
    .div_sel(toctl[`BRTC_PDIV_MSB:`BRTC_PDIV_LSB]),
    .base_1k(ctrl[`BRTC_CTRL_PBASE_1K]),
    .retry(pri_retry),
    .xact_done(pri_xact_done),
    .mto_start(pri_mto_start),
    .mto_stop(pri_mto_stop),
    .retry_timeout(pri_retry_timeout),
    .master_timeout(pri_master_timeout)
);

brtc_port u_sec (
    .core_clk(core_clk),
    .rst(rst),
    .retry_limit(toctl[`BRTC_RETRY_MSB:`BRTC_RETRY_LSB]),
    .div_sel(toctl[`BRTC_SDIV_MSB:`BRTC_SDIV_LSB]),
    .base_1k(ctrl[`BRTC_CTRL_SBASE_1K]),
    .retry(sec_retry),
    .xact_done(sec_xact_done),
    .mto_start(sec_mto_start),
    .mto_stop(sec_mto_stop),
    .retry_timeout(sec_retry_timeout),
    .master_timeout(sec_master_timeout)
);

////////////////////////////////////////////////////////////////////////////////

// Event bits in status order: pri retry, sec retry, pri master, sec master.
assign events = {sec_master_timeout, pri_master_timeout, sec_retry_timeout, pri_retry_timeout};
assign any_rto = pri_retry_timeout | sec_retry_timeout;

// A new event in the cycle of a clearing read survives, so none is lost.
always @* begin
    next_status = status;
    if (rd_clear) begin
        next_status = 4'h0;
    end
    next_status = next_status | events;
end

// The interrupt follows the next status value, so it moves with the status bits.
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        status <= `BRTC_STATUS_RST;
        irq <= 1'b0;
    end else begin
        status <= next_status;
        irq <= |(next_status & mask);
    end
end

////////////////////////////////////////////////////////////////////////////////

// The pins only ever pull low, so the output value stays zero.
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pri_serr_out <= 1'b0;
        sec_serr_out <= 1'b0;
        pri_serr_oe_n <= 1'b1;
        sec_serr_oe_n <= 1'b1;
    end else begin
        pri_serr_out <= 1'b0;
        sec_serr_out <= 1'b0;
        // Either port's retry timeout is reported on every port whose enable is set.
        // The pull lasts one cycle; the bus pull-up returns the pin high afterwards.
        // retry timeout to system error
        pri_serr_oe_n <= ~(any_rto
            & ctrl[`BRTC_CTRL_PSERR_EN]);
        sec_serr_oe_n <= ~(any_rto
            & ctrl[`BRTC_CTRL_SSERR_EN]);
    end
end

endmodule // brtc_top

/* dv/brtc_asserts.sv */
`timescale 1ns/1ps
module brtc_asserts (
    // Clock, reset and bus
    input wire core_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Events and timeouts
    input wire pri_retry,
    input wire sec_retry,
    input wire pri_mto_start,
    input wire sec_mto_start,
    input wire pri_retry_timeout,
    input wire sec_retry_timeout,
    input wire pri_master_timeout,
    input wire sec_master_timeout,
    input wire pri_serr_oe_n,
    input wire sec_serr_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    wire any_rto = pri_retry_timeout || sec_retry_timeout;
    AST_ACK: assert property (s_req |=> wb_ack_o) else $error("no ack");
    AST_ACK1: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_RTO_P: assert property (pri_retry_timeout |-> $past(pri_retry)) else $error("rto p");
    AST_RTO_S: assert property (sec_retry_timeout |-> $past(sec_retry)) else $error("rto s");
    AST_SERR_P: assert property (!pri_serr_oe_n |-> $past(any_rto)) else $error("serr p");
    AST_SERR_S: assert property (!sec_serr_oe_n |-> $past(any_rto)) else $error("serr s");
    AST_MTO_P: assert property (pri_master_timeout |-> !$past(pri_mto_start)) else $error("p");
    AST_MTO_S: assert property (sec_master_timeout |-> !$past(sec_mto_start)) else $error("s");
endmodule // brtc_asserts
bind brtc_top brtc_asserts i_brtc_asserts (.*);

/* dv/brtc_partner.sv */
`timescale 1ns/1ps
module brtc_partner (
    // Clock
    input wire core_clk,
    // Target answers
    output reg pri_retry,
    output reg sec_retry,
    output reg pri_xact_done,
    output reg sec_xact_done
);
    initial {pri_retry, sec_retry, pri_xact_done, sec_xact_done} = 4'h0;
    // A target that retries n attempts, idle for gap cycles after each, then completes.
    task attempt(input bit s, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            {pri_retry, sec_retry} <= {!s, s};
            repeat (gap) @(posedge core_clk) {pri_retry, sec_retry} <= 2'h0;
        end
        @(posedge core_clk);
        {pri_retry, sec_retry, pri_xact_done, sec_xact_done} <= {2'h0, !s, s};
        @(posedge core_clk);
        {pri_xact_done, sec_xact_done} <= 2'h0;
    endtask
endmodule // brtc_partner

/* dv/brtc_top_tb.sv */
`timescale 1ns/1ps
`include "brtc_defines.vh"
module brtc_top_tb;
    logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [13:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic pri_mto_start, pri_mto_stop, sec_mto_start, sec_mto_stop;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, pri_retry, sec_retry, pri_xact_done, sec_xact_done, irq;
    wire pri_retry_timeout, sec_retry_timeout, pri_master_timeout, sec_master_timeout;
    wire pri_serr_out, pri_serr_oe_n, sec_serr_out, sec_serr_oe_n;
    integer fails = 0, comparisons = 0, rto = 0, serr = 0, mtoc = 0;
    int i, b, c, p, n, e, lim, r0, s0;
    logic [7:0] d, q;
    logic [11:0] ix [5] = '{`BRTC_IDX_TOCTL, `BRTC_IDX_STATUS, `BRTC_IDX_MASK, `BRTC_IDX_CTRL, 12'h0a3};
    int sc_code [4] = '{7, 3, 3, 3};
    int sc_n [4] = '{1, 63, 64, 64};
    brtc_top i_brtc_top (.*);
    brtc_partner i_brtc_partner (.*);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        rto <= rto + pri_retry_timeout + sec_retry_timeout;
        serr <= serr + !pri_serr_oe_n + !sec_serr_oe_n;
        mtoc <= mtoc + pri_master_timeout + sec_master_timeout;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wb(input logic we, input logic [11:0] idx, input logic [7:0] dv, input logic [3:0] sel);
        int k;
        logic lane;
        logic [3:0] sl;
        // The timeout byte lives in lane 1, the other registers in lane 0.
        lane = (idx == `BRTC_IDX_TOCTL);
        sl = lane ? sel << 1 : sel;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, we, idx, 2'h0, sl};
        wb_dat_i <= {16'($urandom), dv, lane ? 8'($urandom) : dv};
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = lane ? wb_dat_o[15:8] : wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            wrap_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {core_clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
        {pri_mto_start, pri_mto_stop, sec_mto_start, sec_mto_stop} = 4'h0;
        rst = 1'b1;
        void'($urandom(74));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            wb(0, ix[i], 8'h00, 4'h1);
            chk("reset_value", q, 0);
        end
        repeat (4) begin
            d = $urandom;
            wb(1, `BRTC_IDX_TOCTL, d, 4'h1);
            wb(1, `BRTC_IDX_TOCTL, ~d, 4'h0);
            wb(1, 12'h0a3, ~d, 4'h1);
            wb(0, `BRTC_IDX_TOCTL, 8'h00, 4'h1);
            chk("toctl", q, d & 8'hf7);
        end
        wb(1, `BRTC_IDX_CTRL, 8'h03, 4'h1);
        wb(1, `BRTC_IDX_MASK, 8'h01, 4'h1);
        for (i = 0; i < 4; i++) begin
            wb(1, `BRTC_IDX_TOCTL, 8'(sc_code[i]), 4'h1);
            lim = 1 << (sc_code[i] == 7 ? 0 : 24 - 6 * sc_code[i]);
            e = sc_n[i] >= lim;
            r0 = rto;
            s0 = serr;
            i_brtc_partner.attempt(i[0], sc_n[i], $urandom % 3);
            repeat (3) @(posedge core_clk);
            chk("retry_timeouts", rto - r0, e);
            chk("serr_pulses", serr - s0, 2 * e);
            chk("irq", irq, e && !i[0]);
            wb(0, `BRTC_IDX_STATUS, 8'h00, 4'h1);
            chk("status", q, e << i[0]);
            repeat (2) @(posedge core_clk);
            chk("irq_cleared", irq, 0);
        end
        for (b = 0; b < 2; b++) for (c = 0; c < 4; c++) begin
            p = c[0] ^ b;
            wb(1, `BRTC_IDX_CTRL, b ? 8'h0f : 8'h03, 4'h1);
            wb(1, `BRTC_IDX_TOCTL, {c[1:0], c[1:0], 4'h7}, 4'h1);
            @(posedge core_clk);
            {pri_mto_start, sec_mto_start} <= {!p[0], p[0]};
            @(posedge core_clk);
            {pri_mto_start, sec_mto_start} <= 2'h0;
            n = 0;
            do begin
                @(posedge core_clk);
                #1;
                n++;
            end while ((p ? sec_master_timeout : pri_master_timeout) !== 1'b1 && n < 40000);
            chk("mto_clocks", n, (b ? 1024 : 32768) >> (c == 0 ? 0 : c == 1 ? 3 : c * 4 - 4));
        end
        // Both master timeouts left sticky status bits; the mask lets one through.
        wb(1, `BRTC_IDX_MASK, 8'h04, 4'h1);
        repeat (2) @(posedge core_clk);
        chk("irq_mto", irq, 1);
        wb(0, `BRTC_IDX_STATUS, 8'h00, 4'h1);
        chk("mto_status", q, 8'h0c);
        wb(1, `BRTC_IDX_MASK, 8'h01, 4'h1);
        // A stop right after the start must keep the short count from expiring.
        repeat (2) @(posedge core_clk);
        r0 = mtoc;
        @(posedge core_clk) pri_mto_start <= 1'b1;
        @(posedge core_clk) {pri_mto_start, pri_mto_stop} <= 2'h1;
        @(posedge core_clk) pri_mto_stop <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("mto_stopped", mtoc - r0, 0);
        chk("irq_masked", irq, 0);
        wrap_up;
    end
endmodule // brtc_top_tb
